// ### rtl/tmc_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the 16-bit timer/counter.
 * Assumes an 8-bit register port with byte addresses as given here.
 */
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH
`define TMC_ADDR_FLAGS 8'h0c
`define TMC_ADDR_COUNT_LO 8'h0e
`define TMC_ADDR_COUNT_HI 8'h0f
`define TMC_ADDR_CTRL 8'h10
`define TMC_ADDR_CMP_LO 8'h15
`define TMC_ADDR_CMP_HI 8'h16
`define TMC_ADDR_CMP_CTRL 8'h17
`define TMC_ADDR_ENABLES 8'h8c
`define TMC_BIT_RUN 0
`define TMC_BIT_SRC 1
`define TMC_BIT_BYPASS 2
`define TMC_BIT_OSC 3
`define TMC_PS_LSB 4
`define TMC_BIT_OVF 0
`define TMC_BIT_CMP 2
`define TMC_CTRL_MASK 8'h3f
`define TMC_FLAG_MASK 8'h05
`define TMC_CMP_MODE_MASK 8'h0f
`define TMC_CTRL_RESET 8'h00
`define TMC_FLAGS_RESET 8'h00
`define TMC_ENABLES_RESET 8'h00
`define TMC_CMP_MODE_SEVT 4'hb
`define TMC_COUNT_MAX 16'hffff
`define TMC_PHASE_LAST 2'h3
`endif

// ### rtl/tmc_pkg.sv
/*
 * Types shared by the 16-bit timer/counter.
 * Assumes the constants header is included by the design file.
 */
package tmc_pkg;
  // Register port request from software.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tmc_req_t;

  // Whole state of the timer block.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] count;
    logic [7:0] flags;
    logic [7:0] enables;
    logic [15:0] cmp;
    logic [3:0] cmp_mode;
    logic [7:0] rdata;
    logic irq;
    logic adc_start;
    logic osc_en;
    logic [1:0] phase;
    logic [2:0] pre;
    logic sync1;
    logic sync2;
    logic prev;
    logic armed;
  } tmc_state_t;
endpackage : tmc_pkg

// ### rtl/tmc_timer.sv
/*
 * 16-bit timer/counter with prescaler, external count input, compare special event and
 * overflow interrupt, reached over a plain 8-bit register port.
 * Assumes clk is the oscillator clock, the instruction cycle being one clock in four,
 * and that all inputs are synchronous to clk.
 */
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "tmc_defs.svh"

module tmc_timer (
  input wire logic clk,
  input wire logic rst,
  input wire tmc_pkg::tmc_req_t req,
  output logic [7:0] rdata,
  input wire logic external_count_pin,
  input wire logic adc_enabled,
  output logic adc_start,
  output logic low_power_osc_enable,
  output logic irq
);
  tmc_pkg::tmc_state_t s_q;
  tmc_pkg::tmc_state_t s_d;
  logic run;
  logic src_ext;
  logic bypass;
  logic [1:0] ps;
  logic [2:0] ps_mask;
  logic cur;
  logic rise;
  logic fall;
  logic tick;
  logic inc;
  logic sevt;
  logic wr_lo;
  logic wr_hi;
  logic wrap;

  // Decode of control fields and count events.
  always_comb begin
    run = s_q.ctrl[`TMC_BIT_RUN];
    src_ext = s_q.ctrl[`TMC_BIT_SRC];
    bypass = s_q.ctrl[`TMC_BIT_BYPASS];
    ps = s_q.ctrl[`TMC_PS_LSB +: 2];
    ps_mask = 3'((4'h1 << ps) - 4'h1);
    // Unsynchronised mode samples the pin directly; the synchronised path adds two stages.
    cur = bypass ? external_count_pin : s_q.sync2;
    rise = cur & ~s_q.prev;
    fall = ~cur & s_q.prev;
    tick = src_ext ? (rise & s_q.armed) : (s_q.phase == `TMC_PHASE_LAST);
    inc = run & tick & ((s_q.pre & ps_mask) == ps_mask);
    sevt = (s_q.cmp_mode == `TMC_CMP_MODE_SEVT) && (s_q.count == s_q.cmp);
    wr_lo = req.wr && (req.addr == `TMC_ADDR_COUNT_LO);
    wr_hi = req.wr && (req.addr == `TMC_ADDR_COUNT_HI);
    wrap = inc && (s_q.count == `TMC_COUNT_MAX) && !sevt && !wr_lo && !wr_hi;
  end

  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    s_d.sync1 = external_count_pin;
    s_d.sync2 = s_q.sync1;
    s_d.prev = cur;
    s_d.phase = s_q.phase + 2'h1;
    s_d.adc_start = 1'b0;
    s_d.rdata = 8'h00;
    // Arming restarts whenever counting stops or leaves the external source.
    if (!run || !src_ext) begin
      s_d.armed = 1'b0;
    end else if (fall) begin
      s_d.armed = 1'b1;
    end
    // Prescaler only advances on source ticks and is cleared while stopped.
    if (!run) begin
      s_d.pre = 3'h0;
    end else if (tick) begin
      s_d.pre = s_q.pre + 3'h1;
    end
    if (inc) begin
      s_d.count = s_q.count + 16'h0001;
    end
    // A match clears the count; software writes below override it.
    if (sevt) begin
      s_d.count = 16'h0000;
      s_d.adc_start = adc_enabled;
    end
    if (wr_lo) begin
      s_d.count[7:0] = req.wdata;
    end
    if (wr_hi) begin
      s_d.count[15:8] = req.wdata;
    end
    // Register writes other than the count bytes.
    if (req.wr) begin
      case (req.addr)
        `TMC_ADDR_CTRL: s_d.ctrl = req.wdata & `TMC_CTRL_MASK;
        `TMC_ADDR_FLAGS: s_d.flags = req.wdata & `TMC_FLAG_MASK;
        `TMC_ADDR_ENABLES: s_d.enables = req.wdata & `TMC_FLAG_MASK;
        `TMC_ADDR_CMP_LO: s_d.cmp[7:0] = req.wdata;
        `TMC_ADDR_CMP_HI: s_d.cmp[15:8] = req.wdata;
        `TMC_ADDR_CMP_CTRL: s_d.cmp_mode = req.wdata[3:0];
        default: ;
      endcase
    end
    // Reading the flag register clears it, so a service routine needs no extra write.
    // An event in the same cycle still sets its bit below, so no overflow is lost to the read clear.
    if (req.rd && (req.addr == `TMC_ADDR_FLAGS)) begin
      s_d.flags = `TMC_FLAGS_RESET;
    end
    // Hardware sets win over a software clear in the same cycle.
    if (wrap) begin
      s_d.flags[`TMC_BIT_OVF] = 1'b1;
    end
    if (sevt) begin
      s_d.flags[`TMC_BIT_CMP] = 1'b1;
    end
    s_d.osc_en = s_d.ctrl[`TMC_BIT_OSC];
    s_d.irq = |(s_d.flags & s_d.enables);
    // Read data stand in the cycle after the strobe only.
    if (req.rd) begin
      case (req.addr)
        `TMC_ADDR_FLAGS: s_d.rdata = s_q.flags;
        `TMC_ADDR_COUNT_LO: s_d.rdata = s_q.count[7:0];
        `TMC_ADDR_COUNT_HI: s_d.rdata = s_q.count[15:8];
        `TMC_ADDR_CTRL: s_d.rdata = s_q.ctrl;
        `TMC_ADDR_ENABLES: s_d.rdata = s_q.enables;
        `TMC_ADDR_CMP_LO: s_d.rdata = s_q.cmp[7:0];
        `TMC_ADDR_CMP_HI: s_d.rdata = s_q.cmp[15:8];
        `TMC_ADDR_CMP_CTRL: s_d.rdata = {4'h0, s_q.cmp_mode};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset keeps the count, which no reset defines.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= `TMC_CTRL_RESET;
      s_q.flags <= `TMC_FLAGS_RESET;
      s_q.enables <= `TMC_ENABLES_RESET;
      s_q.count <= s_q.count;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign adc_start = s_q.adc_start;
  assign low_power_osc_enable = s_q.osc_en;
  assign irq = s_q.irq;

  // Checks kept beside the logic.
  a_wrap_sets_flag: assert property (@(posedge clk) disable iff (rst)
    wrap |=> s_q.flags[`TMC_BIT_OVF])
    else $error("overflow flag not set after wrap");

  a_count_holds_stopped: assert property (@(posedge clk) disable iff (rst)
    !run && !sevt && !wr_lo && !wr_hi |=> s_q.count === $past(s_q.count))
    else $error("count moved while stopped");

  a_internal_rate: assert property (@(posedge clk) disable iff (rst)
    inc && !src_ext && ps == 2'h0 |=> !inc ##1 !inc ##1 !inc)
    else $error("internal source faster than one per instruction cycle");

  a_sevt_clears: assert property (@(posedge clk) disable iff (rst)
    sevt && !wr_lo && !wr_hi |=> s_q.count == 16'h0000 && s_q.adc_start == $past(adc_enabled))
    else $error("special event did not clear the count");

  a_sevt_no_ovf: assert property (@(posedge clk) disable iff (rst)
    sevt && !s_q.flags[`TMC_BIT_OVF] && !wr_lo && !wr_hi |=> !s_q.flags[`TMC_BIT_OVF])
    else $error("special event set the overflow flag");

  a_write_wins: assert property (@(posedge clk) disable iff (rst)
    sevt && wr_lo |=> s_q.count[7:0] == $past(req.wdata))
    else $error("count write lost to special event");

  a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
    s_q.flags[`TMC_BIT_OVF] && !((req.wr || req.rd) && req.addr == `TMC_ADDR_FLAGS)
    |=> s_q.flags[`TMC_BIT_OVF])
    else $error("overflow flag dropped without a write");

  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    !s_q.enables[`TMC_BIT_OVF] && !s_q.enables[`TMC_BIT_CMP] |-> !s_q.irq)
    else $error("interrupt raised while masked");

  a_arm_first: assert property (@(posedge clk) disable iff (rst)
    src_ext && !s_q.armed |-> !inc)
    else $error("external count before a falling edge");

  a_prescale_eight: assert property (@(posedge clk) disable iff (rst)
    inc && ps == 2'h3 |=> !inc [*8])
    else $error("divide by eight counted too early");

  a_osc_follows: assert property (@(posedge clk) disable iff (rst)
    req.wr && req.addr == `TMC_ADDR_CTRL |=> low_power_osc_enable == $past(req.wdata[`TMC_BIT_OSC]))
    else $error("oscillator enable does not follow control");

  // The oscillator enable pin mirrors the control bit at all times.
  a_osc_level: assert property (@(posedge clk) disable iff (rst)
    low_power_osc_enable == s_q.ctrl[`TMC_BIT_OSC])
    else $error("oscillator enable differs from control bit");

  // Rollover from all ones lands on zero.
  a_wrap_value: assert property (@(posedge clk) disable iff (rst)
    inc && s_q.count == `TMC_COUNT_MAX && !sevt && !wr_lo && !wr_hi
    |=> s_q.count == 16'h0000)
    else $error("count did not wrap to zero");

  // Each increment adds exactly one.
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    inc && !sevt && !wr_lo && !wr_hi |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("count did not step by one");

  // The interrupt line is the registered OR of unmasked flags.
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == |(s_q.flags & s_q.enables))
    else $error("interrupt level differs from unmasked flags");

  // An enabled and pending overflow must be visible on the line.
  a_ovf_irq_raised: assert property (@(posedge clk) disable iff (rst)
    s_q.flags[`TMC_BIT_OVF] && s_q.enables[`TMC_BIT_OVF] |-> irq)
    else $error("enabled overflow not signalled");

  // A stopped counter never increments.
  a_run_gates: assert property (@(posedge clk) disable iff (rst)
    !run |-> !inc)
    else $error("increment while stopped");

  // Internal source only counts on the last phase of an instruction cycle.
  a_source_internal: assert property (@(posedge clk) disable iff (rst)
    !src_ext && inc |-> s_q.phase == `TMC_PHASE_LAST)
    else $error("internal count off the instruction cycle");

  // External source only counts on an armed rising edge.
  a_ext_on_rise: assert property (@(posedge clk) disable iff (rst)
    src_ext && inc |-> rise && s_q.armed)
    else $error("external count without a rising edge");

  // Divide by one passes every source tick.
  a_prescale_one: assert property (@(posedge clk) disable iff (rst)
    run && tick && ps == 2'h0 |-> inc)
    else $error("divide by one dropped a tick");

  // The second synchroniser stage follows the first by one clock.
  a_sync_chain: assert property (@(posedge clk) disable iff (rst)
    src_ext && !bypass |=> s_q.sync2 == $past(s_q.sync1))
    else $error("synchroniser chain broken");

  // Arming only ever follows a seen falling edge.
  a_armed_after_fall: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.armed) |-> $past(fall))
    else $error("armed without a falling edge");

  // No conversion start while the converter is disabled.
  a_adc_gated: assert property (@(posedge clk) disable iff (rst)
    sevt && !adc_enabled |=> !adc_start)
    else $error("conversion started while converter disabled");

  // Only the trigger mode produces a match clear.
  a_other_mode_quiet: assert property (@(posedge clk) disable iff (rst)
    s_q.cmp_mode != `TMC_CMP_MODE_SEVT |-> !sevt)
    else $error("trigger outside trigger mode");

  // A trigger always leaves the compare flag set.
  a_cmp_flag_set: assert property (@(posedge clk) disable iff (rst)
    sevt |=> s_q.flags[`TMC_BIT_CMP])
    else $error("compare flag not set by trigger");

  // A high byte write also beats the trigger clear.
  a_write_hi_wins: assert property (@(posedge clk) disable iff (rst)
    sevt && wr_hi |=> s_q.count[15:8] == $past(req.wdata))
    else $error("high byte write lost to special event");

  // Reset leaves the count untouched; checked while reset is applied.
  a_reset_keeps: assert property (@(posedge clk)
    rst |=> s_q.count === $past(s_q.count))
    else $error("reset changed the count");
endmodule : tmc_timer

// ### verif/tmc_ext_src.sv
/*
 * Model of the external count source that drives the timer's count pin.
 * Assumes a start pulse synchronous to clk; every pin level is held three clocks.
 */
`timescale 1ns/1ps
module tmc_ext_src (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] edges,
  output logic pin,
  output logic busy
);
  // One lead pulse, whose rise the timer must ignore, then the requested counted rises.
  // The pin idles low between bursts, so no stray fall arms the counter early.
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        repeat (edges + 1) begin
          pin <= 1'b1;
          repeat (3) @(posedge clk);
          pin <= 1'b0;
          repeat (3) @(posedge clk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : tmc_ext_src

// ### verif/testbench.sv
/*
 * Self-checking bench of the 16-bit timer: register calls with expected values.
 * Assumes the constants header and the package are compiled with the design.
 */
`timescale 1ns/1ps
`include "tmc_defs.svh"
module testbench;
  logic clk, rst, pin, adc_en, adc_start, osc, irq, start, busy;
  tmc_pkg::tmc_req_t req;
  logic [7:0] rdata, v, w;
  int bad_count, check_count;

  tmc_timer dut_u (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .external_count_pin(pin),
    .adc_enabled(adc_en), .adc_start(adc_start), .low_power_osc_enable(osc), .irq(irq));
  tmc_ext_src src_u (.clk(clk), .start(start), .edges(8'h10), .pin(pin), .busy(busy));

  // Compare and count; case equality so an unknown never passes.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  // A gap cycle follows every strobe so no strobe is assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
    #1;
  endtask : rd

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Watchdog: the whole sequence needs about 700 clocks.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    req = '0;
    adc_en = 1'b0;
    start = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    rd(`TMC_ADDR_CTRL, v); check("ctrl rst", v, 8'h00);
    rd(`TMC_ADDR_ENABLES, v); check("en rst", v, 8'h00);
    rd(8'h20, v); check("unmapped", v, 8'h00);
    wr(`TMC_ADDR_COUNT_LO, 8'hfe);
    wr(`TMC_ADDR_COUNT_HI, 8'hff);
    wr(`TMC_ADDR_CTRL, 8'h01);
    repeat (40) @(posedge clk);
    wr(`TMC_ADDR_CTRL, 8'h00);
    rd(`TMC_ADDR_COUNT_HI, v); check("wrap hi", v, 8'h00);
    check("irq masked", irq, 1'b0);
    wr(`TMC_ADDR_ENABLES, 8'h01); check("irq on", irq, 1'b1);
    rd(`TMC_ADDR_FLAGS, v); check("ovf flag", v, 8'h01);
    check("irq rd clr", irq, 1'b0);
    wr(`TMC_ADDR_FLAGS, 8'h00); check("irq clr", irq, 1'b0);
    rd(`TMC_ADDR_COUNT_LO, w);
    repeat (20) @(posedge clk);
    rd(`TMC_ADDR_COUNT_LO, v); check("hold", v, w);
    wr(`TMC_ADDR_CTRL, 8'hff);
    rd(`TMC_ADDR_CTRL, v); check("ctrl rsv", v, 8'h3f);
    check("osc on", osc, 1'b1);
    wr(`TMC_ADDR_CTRL, 8'h00); check("osc off", osc, 1'b0);
    wr(`TMC_ADDR_CMP_CTRL, 8'hfb);
    rd(`TMC_ADDR_CMP_CTRL, v); check("cmp mode", v, 8'h0b);
    wr(`TMC_ADDR_CMP_CTRL, 8'h00);
    // Each prescale code on 16 external rises; odd codes bypass the synchroniser.
    for (int ps = 0; ps < 4; ps++) begin
      wr(`TMC_ADDR_COUNT_LO, 8'h5a);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      rd(`TMC_ADDR_COUNT_LO, v); check("kept", v, 8'h5a);
      wr(`TMC_ADDR_COUNT_LO, 8'h00);
      wr(`TMC_ADDR_CTRL, 8'h03 | 8'(ps << 4) | (ps[0] ? 8'h04 : 8'h00));
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      // The model raised busy at the previous edge; look only once it stands.
      @(posedge clk);
      #1;
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
      repeat (6) @(posedge clk);
      #1;
      rd(`TMC_ADDR_COUNT_LO, v); check("ext count", v, 8'(16 >> ps));
    end
    // Compare period of 0x10 on internal timing so the trigger clear is reliable.
    wr(`TMC_ADDR_ENABLES, 8'h01);
    wr(`TMC_ADDR_CMP_LO, 8'h10);
    wr(`TMC_ADDR_CMP_HI, 8'h00);
    wr(`TMC_ADDR_COUNT_LO, 8'h00);
    wr(`TMC_ADDR_COUNT_HI, 8'h00);
    adc_en <= 1'b1;
    wr(`TMC_ADDR_CMP_CTRL, 8'h0b);
    wr(`TMC_ADDR_CTRL, 8'h01);
    for (int i = 0; i < 300 && adc_start !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("adc start", adc_start, 1'b1);
    wr(`TMC_ADDR_CTRL, 8'h00);
    rd(`TMC_ADDR_COUNT_LO, v); check("cleared", 16'(v < 8'h10), 16'h0001);
    rd(`TMC_ADDR_FLAGS, v); check("no ovf", v, 8'h04);
    check("irq cmp", irq, 1'b0);
    give_verdict();
  end
endmodule : testbench
